// [common/spi_cs_consts.vh]
`ifndef SPI_CS_CONSTS_VH
`define SPI_CS_CONSTS_VH
`define OFS_CTRL          8'h00
`define OFS_MODE          8'h04
`define OFS_RXD           8'h08
`define OFS_TXD           8'h0C
`define OFS_STAT          8'h10
`define OFS_IEN           8'h14
`define OFS_IDIS          8'h18
`define OFS_IMASK         8'h1C
`define OFS_CSC_BASE      4'h3
`define OFS_PCFG          8'hE4
`define OFS_PSTAT         8'hE8
`define CTRL_ENABLE       0
`define CTRL_DISABLE      1
`define CTRL_SWRST        7
`define CSC_POL           0
`define CSC_PHASE         1
`define CSC_LEAD_DEASSERT 2
`define CSC_HOLD          3
`define CSC_BITS_LSB      4
`define CSC_BAUD_LSB      8
`define CSC_LEAD_LSB      16
`define CSC_ITD_LSB       24
`define MODE_ISD_LSB      24
`define TXD_CS_LSB        16
`define TXD_LAST          24
`define PCFG_ON           0
`define PCFG_KEY_LSB      8
`define PROTECT_PASSWORD  24'h535049
`define PSTAT_SRC_LSB     8
`define VS_BLOCKED        3'h1
`define VS_SWRST          3'h2
`define VS_ACTIVE         3'h4
`define BITS_BASE         5'h08
`define BITS_MAX          5'h10
`define ITD_UNIT          13'h0020
`define RST_WORD          32'h00000000
`define MIN_DIVIDER       8'h02
`endif

// [logic/baud_gen.v]
`timescale 1ns/1ps
`include "spi_cs_consts.vh"
module baud_gen
(
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       run,
	input  wire [7:0] baud_divider,
	output wire       lead_edge,
	output wire       trail_edge
);
	// A divider below two cannot make two edges per period, so it runs as two.
	wire [7:0] div_eff;
	wire [7:0] half;
	reg  [7:0] cnt_r;

	assign div_eff = (baud_divider < `MIN_DIVIDER) ? `MIN_DIVIDER
		: baud_divider;
	assign half = {1'b0, div_eff[7:1]};

	always @(posedge ref_clk)
	begin
		if (rst || !run)
			cnt_r <= 8'h00;
		else if (cnt_r == div_eff - 8'h01)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end

	assign lead_edge  = run & (cnt_r == 8'h00);
	assign trail_edge = run & (cnt_r == half);
endmodule // baud_gen

// [logic/delay_cnt.v]
`timescale 1ns/1ps
module delay_cnt
(
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        load,
	input  wire [12:0] length,
	output wire        done
);
	reg [12:0] cnt_r;

	always @(posedge ref_clk)
	begin
		if (rst)
			cnt_r <= 13'h0000;
		else if (load)
			cnt_r <= length;
		else if (cnt_r != 13'h0000)
			cnt_r <= cnt_r - 13'h0001;
	end

	assign done = (cnt_r == 13'h0001) & ~load;
endmodule // delay_cnt

// [logic/spi_cs_timing.v]
//Operation
//- Hold off: select rises after last transfer.
//- Hold on: select stays until other select.
//- Length code 0..8 gives 8..16 bits.
//- Serial clock is main clock over divider.
//- Divider fields reset to zero.
//- Lead zero waits half serial period.
//- Lead nonzero waits that many cycles.
//- Gap follows every transfer, before deselect.
//- Gap zero keeps serial clock continuous.
//- Gap is 32 cycles per unit.
//- Protection bit written only with password.
//- Protection bit turns protection on, off.
//- Violation code ORs weights one, two, four.
//- Violations accumulate, clear on status read; weight two also clears on guarded write.
//- Violation source holds register offset.
//- Optional select rise between same-slave transfers.
`timescale 1ns/1ps
`include "spi_cs_consts.vh"
module spi_cs_timing
(
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output wire [3:0]  peripheral_select_line_n,
	output wire        serial_clock_line,
	output wire        mosi,
	input  wire        miso
);
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_LEAD  = 5'h02;
	localparam [4:0] ST_SHIFT = 5'h04;
	localparam [4:0] ST_GAP   = 5'h08;
	localparam [4:0] ST_DESEL = 5'h10;

	wire         wr;
	wire         rd_acc;
	wire         rd_setup;
	wire         is_csc;
	wire [1:0]   csc_idx;
	wire         wr_mode;
	wire         wr_ien;
	wire         wr_idis;
	wire         wr_csc;
	wire         wr_guard;
	wire         blocked;
	wire         swrst;
	wire         soft_rst;
	wire         wr_active;
	wire         mapped;
	wire [127:0] csr_flat;
	wire [31:0]  cur_cfg;
	wire [31:0]  nxt_cfg;
	wire [31:0]  out_cfg;
	wire [4:0]   nb_raw;
	wire [4:0]   nb;
	wire [15:0]  aligned;
	wire [6:0]   half_nz;
	wire [12:0]  lead_len;
	wire [12:0]  gap_len;
	wire [8:0]   isd_raw;
	wire [12:0]  isd_len;
	wire         lead_edge;
	wire         trail_edge;
	wire         dly_done;
	wire         same_cs;
	reg  [31:0]  mode_r;
	reg  [31:0]  imask_r;
	reg          en_r;
	reg          protect_on_r;
	reg  [2:0]   violation_code_r;
	reg  [7:0]   violation_origin_r;
	reg  [31:0]  prdata_r;
	reg          tx_full_r;
	reg  [15:0]  tx_data_r;
	reg  [1:0]   tx_cs_r;
	reg          tx_last_r;
	reg  [15:0]  rx_data_r;
	reg          miso_m_r;
	reg          miso_s_r;
	reg  [4:0]   state_r;
	reg  [4:0]   state_nxt;
	reg          cs_act_r;
	reg          cs_act_nxt;
	reg  [1:0]   cur_cs_r;
	reg  [1:0]   cur_cs_nxt;
	reg          cur_last_r;
	reg          cur_last_nxt;
	reg  [15:0]  shreg_r;
	reg  [15:0]  shreg_nxt;
	reg  [4:0]   bits_left_r;
	reg  [4:0]   bits_left_nxt;
	reg          sclk_ph_r;
	reg          sclk_ph_nxt;
	reg  [15:0]  rx_sh_r;
	reg  [15:0]  rx_sh_nxt;
	reg  [15:0]  rx_data_nxt;
	reg          take;
	reg          load_char;
	reg          finish;
	reg          from_shift;
	reg          dly_load;
	reg  [12:0]  dly_val;
	reg  [3:0]   cs_n_r;
	reg          sclk_r;
	reg          mosi_r;
	reg  [2:0]   vs_clr;
	reg  [2:0]   vs_set;

	assign wr       = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign is_csc   = (paddr[7:4] == `OFS_CSC_BASE) & (paddr[1:0] == 2'h0);
	assign csc_idx  = paddr[3:2];
	assign wr_mode  = wr & (paddr == `OFS_MODE);
	assign wr_ien   = wr & (paddr == `OFS_IEN);
	assign wr_idis  = wr & (paddr == `OFS_IDIS);
	assign wr_csc   = wr & is_csc;
	assign wr_guard = wr_mode | wr_ien | wr_idis | wr_csc;
	assign blocked  = wr_guard & protect_on_r;
	assign swrst    = wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_SWRST];
	assign soft_rst = rst | swrst;
	assign wr_active = cs_act_r & (wr_mode | (wr_csc & csc_idx == cur_cs_r));
	assign mapped = is_csc | (paddr == `OFS_CTRL) | (paddr == `OFS_MODE)
		| (paddr == `OFS_RXD) | (paddr == `OFS_TXD) | (paddr == `OFS_STAT)
		| (paddr == `OFS_IEN) | (paddr == `OFS_IDIS)
		| (paddr == `OFS_IMASK) | (paddr == `OFS_PCFG)
		| (paddr == `OFS_PSTAT);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_r;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_csc
			reg [31:0] cfg_r;
			always @(posedge ref_clk)
			begin
				if (soft_rst)
					cfg_r <= `RST_WORD;
				else if (wr_csc && csc_idx == gi && !protect_on_r)
					cfg_r <= pwdata;
			end
			assign csr_flat[gi * 32 +: 32] = cfg_r;
		end
	endgenerate

	assign cur_cfg = csr_flat[cur_cs_r * 32 +: 32];
	assign nxt_cfg = csr_flat[tx_cs_r * 32 +: 32];
	assign out_cfg = csr_flat[cur_cs_nxt * 32 +: 32];
	assign same_cs = cs_act_r & (cur_cs_r == tx_cs_r);

	// Character is left aligned so the first bit out is always bit 15.
	assign nb_raw  = `BITS_BASE + {1'b0, nxt_cfg[`CSC_BITS_LSB +: 4]};
	assign nb      = (nb_raw > `BITS_MAX) ? `BITS_MAX : nb_raw;
	assign aligned = tx_data_r << (`BITS_MAX - nb);
	assign half_nz = (nxt_cfg[`CSC_BAUD_LSB + 1 +: 7] == 7'h00) ? 7'h01
		: nxt_cfg[`CSC_BAUD_LSB + 1 +: 7];
	assign lead_len = (nxt_cfg[`CSC_LEAD_LSB +: 8] == 8'h00)
		? {6'h00, half_nz}
		: {5'h00, nxt_cfg[`CSC_LEAD_LSB +: 8]};
	assign gap_len = {5'h00, cur_cfg[`CSC_ITD_LSB +: 8]} * `ITD_UNIT;
	assign isd_raw = (cur_cfg[`CSC_ITD_LSB +: 8] != 8'h00)
		? {1'b0, mode_r[`MODE_ISD_LSB +: 8]}
		: {1'b0, mode_r[`MODE_ISD_LSB +: 8]} + 9'h001;
	assign isd_len = (isd_raw == 9'h000) ? 13'h0001 : {4'h0, isd_raw};

	baud_gen u_baud
	(
		.ref_clk      (ref_clk),
		.rst          (soft_rst),
		.run          (state_r == ST_SHIFT),
		.baud_divider (cur_cfg[`CSC_BAUD_LSB +: 8]),
		.lead_edge    (lead_edge),
		.trail_edge   (trail_edge)
	);

	delay_cnt u_delay
	(
		.ref_clk (ref_clk),
		.rst     (soft_rst),
		.load    (dly_load),
		.length  (dly_val),
		.done    (dly_done)
	);

	always @*
	begin
		state_nxt     = state_r;
		cs_act_nxt    = cs_act_r;
		cur_cs_nxt    = cur_cs_r;
		cur_last_nxt  = cur_last_r;
		shreg_nxt     = shreg_r;
		bits_left_nxt = bits_left_r;
		sclk_ph_nxt   = sclk_ph_r;
		rx_sh_nxt     = rx_sh_r;
		rx_data_nxt   = rx_data_r;
		take          = 1'b0;
		load_char     = 1'b0;
		finish        = 1'b0;
		from_shift    = 1'b0;
		dly_load      = 1'b0;
		dly_val       = 13'h0000;
		case (state_r)
			ST_IDLE:
			begin
				if (en_r && tx_full_r)
				begin
					if (cs_act_r && !same_cs)
					begin
						cs_act_nxt = 1'b0;
						state_nxt  = ST_DESEL;
						dly_load   = 1'b1;
						dly_val    = isd_len;
					end
					else if (same_cs)
					begin
						load_char = 1'b1;
						state_nxt = ST_SHIFT;
					end
					else
					begin
						cs_act_nxt = 1'b1;
						cur_cs_nxt = tx_cs_r;
						load_char  = 1'b1;
						if (lead_len == 13'h0001)
							state_nxt = ST_SHIFT;
						else
						begin
							state_nxt = ST_LEAD;
							dly_load  = 1'b1;
							dly_val   = lead_len - 13'h0001;
						end
					end
				end
			end
			ST_LEAD:
			begin
				if (dly_done)
					state_nxt = ST_SHIFT;
			end
			ST_SHIFT:
			begin
				if (lead_edge)
				begin
					sclk_ph_nxt = 1'b1;
					rx_sh_nxt   = {rx_sh_r[14:0], miso_s_r};
				end
				if (trail_edge)
				begin
					sclk_ph_nxt = 1'b0;
					if (bits_left_r == 5'h01)
					begin
						rx_data_nxt = rx_sh_r;
						if (cur_cfg[`CSC_ITD_LSB +: 8] != 8'h00)
						begin
							state_nxt = ST_GAP;
							dly_load  = 1'b1;
							dly_val   = gap_len;
						end
						else
						begin
							finish     = 1'b1;
							from_shift = 1'b1;
						end
					end
					else
					begin
						shreg_nxt     = {shreg_r[14:0], 1'b0};
						bits_left_nxt = bits_left_r - 5'h01;
					end
				end
			end
			ST_GAP:
			begin
				if (dly_done)
					finish = 1'b1;
			end
			ST_DESEL:
			begin
				if (dly_done)
					state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (finish)
		begin
			if (!cur_cfg[`CSC_HOLD]
				&& (cur_last_r || cur_cfg[`CSC_LEAD_DEASSERT]))
			begin
				cs_act_nxt = 1'b0;
				if (isd_len == 13'h0001)
					state_nxt = ST_IDLE;
				else
				begin
					state_nxt = ST_DESEL;
					dly_load  = 1'b1;
					dly_val   = isd_len - 13'h0001;
				end
			end
			else if (from_shift && en_r && tx_full_r && same_cs)
			begin
				load_char = 1'b1;
				state_nxt = ST_SHIFT;
			end
			else
				state_nxt = ST_IDLE;
		end
		if (load_char)
		begin
			take          = 1'b1;
			shreg_nxt     = aligned;
			rx_sh_nxt     = 16'h0000;
			bits_left_nxt = nb;
			cur_last_nxt  = tx_last_r;
		end
	end

	always @*
	begin
		vs_clr = rd_acc && paddr == `OFS_PSTAT ? prdata_r[2:0] : 3'h0;
		if (wr_guard)
			vs_clr = vs_clr | `VS_SWRST;
		vs_set = 3'h0;
		if (blocked)
			vs_set = vs_set | `VS_BLOCKED;
		if (swrst && protect_on_r)
			vs_set = vs_set | `VS_SWRST;
		if (wr_active)
			vs_set = vs_set | `VS_ACTIVE;
	end

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			protect_on_r       <= 1'b0;
			violation_code_r   <= 3'h0;
			violation_origin_r <= 8'h00;
			prdata_r           <= `RST_WORD;
			miso_m_r           <= 1'b0;
			miso_s_r           <= 1'b0;
		end
		else
		begin
			miso_m_r <= miso;
			miso_s_r <= miso_m_r;
			if (wr && paddr == `OFS_PCFG
				&& pwdata[`PCFG_KEY_LSB +: 24] == `PROTECT_PASSWORD)
				protect_on_r <= pwdata[`PCFG_ON];
			violation_code_r <= (violation_code_r & ~vs_clr) | vs_set;
			if (blocked || wr_active)
				violation_origin_r <= paddr;
			if (rd_setup)
			begin
				case (paddr)
					`OFS_MODE:  prdata_r <= mode_r;
					`OFS_RXD:   prdata_r <= {16'h0000, rx_data_r};
					`OFS_STAT:  prdata_r <= {29'h00000000, en_r,
						state_r != ST_IDLE, ~tx_full_r};
					`OFS_IMASK: prdata_r <= imask_r;
					`OFS_PCFG:  prdata_r <= {31'h00000000, protect_on_r};
					`OFS_PSTAT: prdata_r <= {16'h0000, violation_origin_r,
						5'h00, violation_code_r};
					default:    prdata_r <= is_csc ? csr_flat[csc_idx * 32 +: 32]
						: `RST_WORD;
				endcase
			end
		end
	end

	always @(posedge ref_clk)
	begin
		if (soft_rst)
		begin
			mode_r      <= `RST_WORD;
			imask_r     <= `RST_WORD;
			en_r        <= 1'b0;
			tx_full_r   <= 1'b0;
			tx_data_r   <= 16'h0000;
			tx_cs_r     <= 2'h0;
			tx_last_r   <= 1'b0;
			rx_data_r   <= 16'h0000;
			state_r     <= ST_IDLE;
			cs_act_r    <= 1'b0;
			cur_cs_r    <= 2'h0;
			cur_last_r  <= 1'b0;
			shreg_r     <= 16'h0000;
			bits_left_r <= 5'h00;
			sclk_ph_r   <= 1'b0;
			rx_sh_r     <= 16'h0000;
			cs_n_r      <= 4'hF;
			sclk_r      <= 1'b0;
			mosi_r      <= 1'b0;
		end
		else
		begin
			if (wr_mode && !protect_on_r)
				mode_r <= pwdata;
			if (wr_ien && !protect_on_r)
				imask_r <= imask_r | pwdata;
			else if (wr_idis && !protect_on_r)
				imask_r <= imask_r & ~pwdata;
			if (wr && paddr == `OFS_CTRL && pwdata[`CTRL_DISABLE])
				en_r <= 1'b0;
			else if (wr && paddr == `OFS_CTRL && pwdata[`CTRL_ENABLE])
				en_r <= 1'b1;
			if (wr && paddr == `OFS_TXD && !tx_full_r)
			begin
				tx_full_r <= 1'b1;
				tx_data_r <= pwdata[15:0];
				tx_cs_r   <= pwdata[`TXD_CS_LSB +: 2];
				tx_last_r <= pwdata[`TXD_LAST];
			end
			else if (take)
				tx_full_r <= 1'b0;
			rx_data_r   <= rx_data_nxt;
			state_r     <= state_nxt;
			cs_act_r    <= cs_act_nxt;
			cur_cs_r    <= cur_cs_nxt;
			cur_last_r  <= cur_last_nxt;
			shreg_r     <= shreg_nxt;
			bits_left_r <= bits_left_nxt;
			sclk_ph_r   <= sclk_ph_nxt;
			rx_sh_r     <= rx_sh_nxt;
			cs_n_r      <= cs_act_nxt ? ~(4'h1 << cur_cs_nxt) : 4'hF;
			sclk_r      <= out_cfg[`CSC_POL] ^ sclk_ph_nxt;
			mosi_r      <= shreg_nxt[15];
		end
	end

	assign peripheral_select_line_n = cs_n_r;
	assign serial_clock_line        = sclk_r;
	assign mosi                     = mosi_r;
endmodule // spi_cs_timing

// [sim/spi_cs_timing_props.sv]
`timescale 1ns/1ps
module spi_cs_timing_props
(
	input wire        ref_clk,
	input wire        rst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [3:0]  peripheral_select_line_n,
	input wire        serial_clock_line,
	input wire        mosi,
	input wire        miso
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_ONE_SEL: assert property ($countones(~peripheral_select_line_n) <= 1)
		else $error("more than one select low");
	AST_RST_IDLE: assert property (disable iff (1'b0)
		rst |=> peripheral_select_line_n == 4'hF && !serial_clock_line)
		else $error("select or clock not idle after reset");
	AST_LEAD: assert property ($fell(&peripheral_select_line_n) |->
		$stable(serial_clock_line))
		else $error("serial clock moved right at select");
	AST_IDLE_CLK: assert property (&peripheral_select_line_n
		&& $past(&peripheral_select_line_n) |-> $stable(serial_clock_line))
		else $error("serial clock moved with no select");
	AST_SEL_CLK: assert property ($changed(peripheral_select_line_n) |->
		!serial_clock_line)
		else $error("select changed with clock active");
	AST_PRDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=>
		$stable(prdata))
		else $error("read data changed without read");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	AST_ERR_ZERO: assert property (psel && penable && !pwrite && pslverr
		|-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule // spi_cs_timing_props
bind spi_cs_timing spi_cs_timing_props u_props
(
	.ref_clk(ref_clk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.peripheral_select_line_n(peripheral_select_line_n),
	.serial_clock_line(serial_clock_line),
	.mosi(mosi),
	.miso(miso)
);

// [sim/spi_slave_model.sv]
`timescale 1ns/1ps
module spi_slave_model
#(
	parameter [15:0] TX_WORD = 16'hB38E
)
(
	input  wire        ref_clk,
	input  wire [3:0]  sel_n,
	input  wire        sclk,
	input  wire        mosi,
	output reg         miso,
	output reg  [15:0] rx_word,
	output integer     nbits,
	output integer     lead,
	output integer     pmax,
	output integer     tail,
	output integer     frames
);
	integer cyc;
	integer t_fall;
	integer t_rise;
	integer t_edge;
	reg     clk_q;
	reg     act_q;
	wire    act = ~&sel_n;
	initial
	begin
		cyc = 0;
		frames = 0;
		miso = 1'b0;
		clk_q = 1'b0;
		act_q = 1'b0;
	end
	always @(negedge ref_clk)
	begin
		cyc = cyc + 1;
		if (act && !act_q)
		begin
			t_fall = cyc;
			t_rise = -1;
			nbits = 0;
			pmax = 0;
			lead = -1;
			rx_word = 16'h0000;
			miso = TX_WORD[15];
		end
		else if (!act)
			miso = ~miso; // A released line shows no stale bit.
		if (act && sclk !== clk_q)
		begin
			if (lead < 0)
				lead = cyc - t_fall;
			t_edge = cyc;
			if (sclk)
			begin
				rx_word = {rx_word[14:0], mosi};
				nbits = nbits + 1;
				if (t_rise >= 0 && cyc - t_rise > pmax)
					pmax = cyc - t_rise;
				t_rise = cyc;
			end
			else if (nbits < 16)
				miso = TX_WORD[15 - nbits];
		end
		if (!act && act_q)
		begin
			tail = cyc - t_edge;
			frames = frames + 1;
		end
		clk_q = sclk;
		act_q = act;
	end
endmodule // spi_slave_model

// [sim/spi_cs_timing_bench.sv]
`timescale 1ns/1ps
`include "spi_cs_consts.vh"
module spi_cs_timing_bench;
	localparam [15:0] SLAVE_WORD = 16'hB38E;
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h00000000;
	reg  [31:0] rd;
	reg  [31:0] seed = 32'h00000044;
	wire [31:0] prdata;
	wire [3:0]  sel_n;
	wire [15:0] rx_word;
	wire        sclk;
	wire        mosi;
	wire        miso;
	integer     nbits, lead, pmax, tail, frames, i, t1;
	integer     n_mismatch = 0;
	integer     checked = 0;
	integer     cycles = 0;
	integer     m_csc [0:3];
	integer     m_prot = 0;
	integer     m_vs = 0;
	integer     m_src = 0;
	spi_cs_timing u_spi_cs_timing
	(
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(), .pslverr(), .peripheral_select_line_n(sel_n),
		.serial_clock_line(sclk), .mosi(mosi), .miso(miso)
	);
	spi_slave_model #(.TX_WORD(SLAVE_WORD)) u_spi_slave_model
	(
		.ref_clk(ref_clk), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
		.miso(miso), .rx_word(rx_word), .nbits(nbits), .lead(lead),
		.pmax(pmax), .tail(tail), .frames(frames)
	);
	initial
		forever #12.5 ref_clk = ~ref_clk;
	task report_and_stop;
	begin
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	always @(posedge ref_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 40000)
		begin
			n_mismatch = n_mismatch + 1;
			report_and_stop;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	function [31:0] xs(input [31:0] s);
	reg [31:0] t;
	begin
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	end
	endfunction
	task bus(input w, input [7:0] a, input [31:0] d);
	begin
		@(negedge ref_clk);
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(negedge ref_clk);
		penable = 1'b1;
		@(posedge ref_clk);
		rd = prdata;
		@(negedge ref_clk);
		psel = 1'b0;
		penable = 1'b0;
		if (w && (a == `OFS_MODE || a == `OFS_IEN || a == `OFS_IDIS ||
			a[7:4] == `OFS_CSC_BASE))
		begin
			m_vs = m_vs & 3'h5;
			if (m_prot)
			begin
				m_vs = m_vs | 3'h1;
				m_src = a;
			end
			else if (a[7:4] == `OFS_CSC_BASE)
				m_csc[a[3:2]] = d;
		end
		if (w && a == `OFS_PCFG && d[31:8] == `PROTECT_PASSWORD)
			m_prot = d[0];
		if (w && a == `OFS_CTRL && d[7])
		begin
			m_vs = m_vs | (m_prot ? 3'h2 : 3'h0);
			for (i = 0; i < 4; i = i + 1)
				m_csc[i] = 0;
		end
		if (!w && a[7:4] == `OFS_CSC_BASE)
			chk(rd, m_csc[a[3:2]]);
		if (!w && a == `OFS_PSTAT)
		begin
			chk(rd, m_src * 256 + m_vs);
			m_vs = 0;
		end
	end
	endtask
	task xfer(input [1:0] cs, input [31:0] cfg, input [15:0] d);
	reg [15:0] mask;
	begin
		mask = 16'hFFFF >> (8 - cfg[7:4]);
		bus(1'b1, {`OFS_CSC_BASE, cs, 2'b00}, cfg);
		bus(1'b1, `OFS_TXD, {8'h01, 6'h00, cs, d});
		wait (sel_n[cs] === 1'b0);
		chk(sel_n, {28'h0000000, ~(4'h1 << cs)});
		wait (sel_n === 4'hF);
		@(posedge ref_clk);
		chk(nbits, 8 + cfg[7:4]);
		chk(rx_word & mask, d & mask);
		chk(pmax, cfg[15:8]);
		chk(lead, cfg[23:16] ? cfg[23:16] : cfg[15:8] >> 1);
	end
	endtask
	task pair(input [3:0] fl, input integer nf);
	integer f0;
	begin
		f0 = frames;
		bus(1'b1, {`OFS_CSC_BASE, 4'h0}, {24'h000008, 4'h0, fl});
		bus(1'b1, `OFS_TXD, 32'h000000C3);
		bus(1'b1, `OFS_TXD, 32'h0100003C);
		wait (frames == f0 + nf);
		repeat (100) @(negedge ref_clk);
		chk(frames - f0, nf);
		chk(pmax, 8);
		chk(rx_word, nf == 1 ? 16'hC33C : 16'h003C);
	end
	endtask
	initial
	begin
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		for (i = 0; i < 4; i = i + 1)
			m_csc[i] = 0;
		for (t1 = 0; t1 < 4; t1 = t1 + 1)
			bus(1'b0, {`OFS_CSC_BASE, t1[1:0], 2'b00}, 0);
		bus(1'b0, 8'h40, 0);
		chk(rd, 32'h00000000);
		bus(1'b0, `OFS_PSTAT, 0);
		bus(1'b1, `OFS_CTRL, 32'h00000001);
		$display("reset test done");
		for (t1 = 0; t1 < 9; t1 = t1 + 1)
		begin
			seed = xs(seed);
			xfer(2'h0, {20'h00008, t1[3:0], 4'h0}, seed[15:0]);
			bus(1'b0, `OFS_RXD, 0);
			chk(rd, SLAVE_WORD >> (8 - t1));
		end
		$display("length test done");
		xfer(2'h1, 32'h00050500, 16'h5A5A);
		xfer(2'h3, 32'h01000800, 16'h00F0);
		t1 = tail;
		xfer(2'h3, 32'h02000800, 16'h000F);
		chk(tail - t1, 32);
		$display("timing test done");
		bus(1'b1, {`OFS_CSC_BASE, 4'h8}, 32'h0000FF08);
		bus(1'b1, `OFS_TXD, 32'h00020096);
		wait (sel_n === 4'hB);
		bus(1'b1, {`OFS_CSC_BASE, 4'h8}, 32'h0000FF08);
		m_vs = m_vs | 3'h4;
		m_src = 8'h38;
		wait (nbits == 8);
		repeat (300) @(negedge ref_clk);
		chk(sel_n, 4'hB);
		bus(1'b0, `OFS_PSTAT, 0);
		xfer(2'h1, 32'h00050500, 16'hA5A5);
		$display("hold test done");
		pair(4'h0, 1);
		pair(4'h4, 2);
		$display("gap test done");
		bus(1'b1, `OFS_PCFG, 32'h12345601);
		bus(1'b1, {`OFS_CSC_BASE, 4'h0}, 32'h00000808);
		bus(1'b0, {`OFS_CSC_BASE, 4'h0}, 0);
		bus(1'b1, `OFS_PCFG, 32'h53504901);
		bus(1'b1, {`OFS_CSC_BASE, 4'h0}, 32'h0000FF08);
		bus(1'b0, {`OFS_CSC_BASE, 4'h0}, 0);
		bus(1'b1, `OFS_MODE, 32'h00000000);
		bus(1'b0, `OFS_PSTAT, 0);
		bus(1'b0, `OFS_PSTAT, 0);
		bus(1'b1, `OFS_CTRL, 32'h00000080);
		bus(1'b0, `OFS_PSTAT, 0);
		bus(1'b1, `OFS_CTRL, 32'h00000080);
		bus(1'b1, `OFS_IDIS, 32'h00000000);
		bus(1'b0, `OFS_PSTAT, 0);
		bus(1'b0, {`OFS_CSC_BASE, 4'h0}, 0);
		bus(1'b1, `OFS_PCFG, 32'h53504900);
		bus(1'b1, {`OFS_CSC_BASE, 4'h0}, 32'h00000908);
		bus(1'b0, {`OFS_CSC_BASE, 4'h0}, 0);
		$display("protect test done");
		report_and_stop;
	end
endmodule // spi_cs_timing_bench
